// ### verilog/pmt_pkg.sv
// shared constants for the period match timer
package pmt_pkg;

  // apb geometry
  localparam int unsigned PMT_ADDR_W = 16;
  localparam int unsigned PMT_DATA_W = 32;
  localparam int unsigned PMT_REG_W = 8;

  // register indices; the byte address is four times the index
  localparam logic [11:0] PMT_IDX_CONTROL = 12'hFCA;
  localparam logic [11:0] PMT_IDX_COUNT = 12'hFCB;
  localparam logic [11:0] PMT_IDX_PERIOD = 12'hFCC;
  localparam logic [11:0] PMT_IDX_FLAG = 12'hFCD;
  localparam logic [11:0] PMT_IDX_ENABLE = 12'hFCE;

  // control register fields
  localparam int unsigned PMT_CTL_PRE_LSB = 0;
  localparam int unsigned PMT_CTL_PRE_MSB = 1;
  localparam int unsigned PMT_CTL_ON_BIT = 2;
  localparam int unsigned PMT_CTL_POST_LSB = 3;
  localparam int unsigned PMT_CTL_POST_MSB = 6;
  localparam logic [7:0] PMT_CTL_WMASK = 8'h7F;

  // flag and enable registers share one layout
  localparam int unsigned PMT_IRQ_MATCH_BIT = 1;
  localparam logic [7:0] PMT_IRQ_WMASK = 8'h02;

  // reset values
  localparam logic [7:0] PMT_CONTROL_RST = 8'h00;
  localparam logic [7:0] PMT_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RST = 8'hFF;
  localparam logic [7:0] PMT_ENABLE_RST = 8'h00;

  // timing: instruction clock is the system clock divided by four
  localparam int unsigned PMT_INSTR_DIV = 4;
  localparam logic [1:0] PMT_INSTR_LAST = 2'(PMT_INSTR_DIV - 1);

  // prescaler select codes and divide ratios minus one
  localparam logic [1:0] PMT_PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PMT_PRE_SEL_4 = 2'h1;
  localparam logic [3:0] PMT_PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PMT_PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PMT_PRE_LAST_16 = 4'hF;

endpackage : pmt_pkg

// ### verilog/pmt_tick_if.sv
// tick bundle between the timer core and its clock divider
`timescale 1ns/1ps
interface pmt_tick_if;
  logic clr;
  logic run;
  logic [1:0] sel;
  logic instr_en;
  logic tick;

  modport core (output clr, output run, output sel, input instr_en, input tick);
  modport div (input clr, input run, input sel, output instr_en, output tick);
endinterface : pmt_tick_if

// ### verilog/pmt_clk_div.sv
// instruction clock enable and selectable prescaler
`timescale 1ns/1ps
module pmt_clk_div
  import pmt_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  pmt_tick_if.div tick_bus
);
  import pmt_pkg::*;

  logic [1:0] instr_cnt;
  logic [3:0] pre_cnt;
  logic [3:0] pre_last;
  logic instr_en;

  // free running divide by four; not cleared by register writes
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      instr_cnt <= 2'h0;
    end else begin
      instr_cnt <= (instr_cnt == PMT_INSTR_LAST) ? 2'h0 : instr_cnt + 2'h1;
    end
  end

  assign instr_en = (instr_cnt == PMT_INSTR_LAST);

  // ratio select, codes 2 and 3 both divide by sixteen
  always_comb begin
    if (tick_bus.sel == PMT_PRE_SEL_1) begin
      pre_last = PMT_PRE_LAST_1;
    end else if (tick_bus.sel == PMT_PRE_SEL_4) begin
      pre_last = PMT_PRE_LAST_4;
    end else begin
      pre_last = PMT_PRE_LAST_16;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt <= 4'h0;
    end else if (tick_bus.clr) begin
      pre_cnt <= 4'h0;
    end else if (tick_bus.run && instr_en) begin
      pre_cnt <= (pre_cnt >= pre_last) ? 4'h0 : pre_cnt + 4'h1;
    end
  end

  assign tick_bus.instr_en = instr_en;
  assign tick_bus.tick = tick_bus.run && instr_en && !tick_bus.clr && (pre_cnt >= pre_last);

endmodule : pmt_clk_div

// ### verilog/pmt_timer.sv
// period match timer with apb registers, postscaler and interrupt
`timescale 1ns/1ps

// Summary of operation
// - when on, count advances by one from zero on each prescaled instruction tick
// - prescaler divides by 1, 4 or 16 per two-bit select in control bits 1:0
// - count is compared with period every tick; equality gives the match output
// - after a match the count reloads zero instead of incrementing
// - each match clocks a four-bit postscaler, ratio select plus one, bits 6:3
// - postscaler output sets the latched flag; interrupt only while enable bit set
// - reset clears count and loads period with all ones
// - writes to count or control and any reset clear both scalers
// - a control write leaves the count unchanged
// - control bit 2 runs the timer; cleared, the count holds
// - count and period are readable and writable at any time
// - the unscaled match pulse is the pwm time base for capture/compare units
// - the timer output is offered as a shift clock to the serial port
// - clearing after a match gives a pulse one instruction cycle long
module pmt_timer
  import pmt_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [pmt_pkg::PMT_ADDR_W-1:0] i_paddr,
  input wire logic [pmt_pkg::PMT_DATA_W-1:0] i_pwdata,
  output logic [pmt_pkg::PMT_DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_pwm_timebase,
  output logic o_spi_shift_clk,
  output logic o_gate_pulse
);
  import pmt_pkg::*;

  // register state
  logic [7:0] control_register;
  logic [7:0] timer_count;
  logic [7:0] period_value;
  logic match_irq_flag;
  logic match_irq_enable;
  logic [3:0] post_cnt;
  logic gate_hold;

  // apb decode
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic addr_ok;
  logic [11:0] reg_idx;
  logic hit_control;
  logic hit_count;
  logic hit_period;
  logic hit_flag;
  logic hit_enable;
  logic [7:0] wdata;
  logic [7:0] next_rdata;
  logic flag_snap;

  // timer events
  logic match;
  logic match_evt;
  logic post_evt;
  logic scaler_clr;

  pmt_tick_if tick_bus ();

  pmt_clk_div u_div (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .tick_bus(tick_bus)
  );

  // word aligned index; low two address bits must be zero
  assign reg_idx = i_paddr[13:2];
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[PMT_ADDR_W-1:14] == 2'h0);
  assign hit_control = addr_ok && (reg_idx == PMT_IDX_CONTROL);
  assign hit_count = addr_ok && (reg_idx == PMT_IDX_COUNT);
  assign hit_period = addr_ok && (reg_idx == PMT_IDX_PERIOD);
  assign hit_flag = addr_ok && (reg_idx == PMT_IDX_FLAG);
  assign hit_enable = addr_ok && (reg_idx == PMT_IDX_ENABLE);
  assign wdata = i_pwdata[7:0];

  // pready is registered, so every transfer gets one wait state
  assign access = i_psel && i_penable;
  assign done = access && o_pready;
  assign wr_done = done && i_pwrite && !o_pslverr;
  assign rd_done = done && !i_pwrite && !o_pslverr;

  // read mux; reserved and upper bits read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (hit_control) begin
      next_rdata = control_register & PMT_CTL_WMASK;
    end else if (hit_count) begin
      next_rdata = timer_count;
    end else if (hit_period) begin
      next_rdata = period_value;
    end else if (hit_flag) begin
      next_rdata[PMT_IRQ_MATCH_BIT] = match_irq_flag;
    end else if (hit_enable) begin
      next_rdata[PMT_IRQ_MATCH_BIT] = match_irq_enable;
    end
  end

  // apb answer: ready one cycle into the access phase, error on unmapped
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      flag_snap <= 1'b0;
    end else if (access && !o_pready) begin
      o_pready <= 1'b1;
      o_pslverr <= !(hit_control || hit_count || hit_period || hit_flag || hit_enable);
      o_prdata <= {24'h000000, i_pwrite ? 8'h00 : next_rdata};
      flag_snap <= hit_flag && !i_pwrite && match_irq_flag;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      flag_snap <= 1'b0;
    end
  end

  // scaler clear on count or control write
  assign scaler_clr = wr_done && (hit_count || hit_control);

  assign tick_bus.clr = scaler_clr;
  assign tick_bus.run = control_register[PMT_CTL_ON_BIT];
  assign tick_bus.sel = control_register[PMT_CTL_PRE_MSB:PMT_CTL_PRE_LSB];

  // control write loads the control register and clears both scalers, not the count
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      control_register <= PMT_CONTROL_RST;
    end else if (wr_done && hit_control) begin
      control_register <= wdata & PMT_CTL_WMASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      period_value <= PMT_PERIOD_RST;
    end else if (wr_done && hit_period) begin
      period_value <= wdata;
    end
  end

  assign match = (timer_count == period_value);
  assign match_evt = tick_bus.tick && match;

  // a software write wins over a coincident tick
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      timer_count <= PMT_COUNT_RST;
    end else if (wr_done && hit_count) begin
      timer_count <= wdata;
    end else if (match_evt) begin
      timer_count <= 8'h00;
    end else if (tick_bus.tick) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  assign post_evt = match_evt && !scaler_clr &&
    (post_cnt == control_register[PMT_CTL_POST_MSB:PMT_CTL_POST_LSB]);
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      post_cnt <= 4'h0;
    end else if (scaler_clr) begin
      post_cnt <= 4'h0;
    end else if (post_evt) begin
      post_cnt <= 4'h0;
    end else if (match_evt) begin
      post_cnt <= post_cnt + 4'h1;
    end
  end

  // latched flag; read clears only what was seen, a new set wins
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_irq_flag <= 1'b0;
    end else if (post_evt) begin
      match_irq_flag <= 1'b1;
    end else if (rd_done && hit_flag && flag_snap) begin
      match_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_irq_enable <= PMT_ENABLE_RST[PMT_IRQ_MATCH_BIT];
    end else if (wr_done && hit_enable) begin
      match_irq_enable <= wdata[PMT_IRQ_MATCH_BIT];
    end
  end

  // level interrupt, one cycle behind the flag
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= match_irq_flag && match_irq_enable;
    end
  end

  // unscaled match pulse to capture/compare units
  // same pulse offered to the serial port as shift clock source
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pwm_timebase <= 1'b0;
      o_spi_shift_clk <= 1'b0;
    end else begin
      o_pwm_timebase <= match_evt;
      o_spi_shift_clk <= match_evt;
    end
  end

  // gate pulse held until the next instruction enable, four clocks
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gate_hold <= 1'b0;
    end else if (match_evt) begin
      gate_hold <= 1'b1;
    end else if (tick_bus.instr_en) begin
      gate_hold <= 1'b0;
    end
  end

  // registered copy keeps the output straight from a flop
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_gate_pulse <= 1'b0;
    end else begin
      o_gate_pulse <= gate_hold;
    end
  end

endmodule : pmt_timer

// ### dv/pmt_checker.sv
// port assertions for the period match timer
`timescale 1ns/1ps
module pmt_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_irq,
  input wire logic o_pwm_timebase,
  input wire logic o_spi_shift_clk,
  input wire logic o_gate_pulse
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // bus answers after exactly one wait state
  property p_rdy_wait; i_psel && i_penable && !o_pready |=> o_pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
  property p_rdy_pulse; o_pready |=> !o_pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready long");
  property p_err; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_hi0; o_pready |-> o_prdata[31:8] == 24'h0; endproperty
  a_hi0: assert property (p_hi0) else $error("upper data set");
  // shift clock and pwm outputs share one unscaled pulse; gate follows it for four clocks
  property p_spi; o_spi_shift_clk == o_pwm_timebase; endproperty
  a_spi: assert property (p_spi) else $error("shift clock differs");
  property p_pwm; o_pwm_timebase |=> !o_pwm_timebase; endproperty
  a_pwm: assert property (p_pwm) else $error("match pulse long");
  property p_gate; o_pwm_timebase |=> o_gate_pulse [*4]; endproperty
  a_gate: assert property (p_gate) else $error("gate pulse short");
  property p_gate_src; $rose(o_gate_pulse) |-> $past(o_pwm_timebase); endproperty
  a_gate_src: assert property (p_gate_src) else $error("gate without match");
  // irq moves only after a match or a register access
  property p_irq_up; $rose(o_irq) |-> $past(o_pwm_timebase) || $past(o_pready, 2); endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose unprompted");
  property p_irq_dn; $fell(o_irq) |-> $past(o_pready, 2); endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell unprompted");
  c_err: cover property (o_pslverr);
  c_irq: cover property ($rose(o_irq));
  c_gate: cover property ($rose(o_gate_pulse));
endmodule : pmt_checker

bind pmt_timer pmt_checker i_chk (
  .i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_irq(o_irq),
  .o_pwm_timebase(o_pwm_timebase),
  .o_spi_shift_clk(o_spi_shift_clk),
  .o_gate_pulse(o_gate_pulse)
);

// ### dv/tb_top.sv
// self-checking bench for the period match timer
`timescale 1ns/1ps
module tb_top;
  import pmt_pkg::*;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, pwm, er, spi, gate;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int err_total = 0;
  int checks_done = 0;
  int t, n, dv;
  // postscale codes exercised: 1:1, 1:4 and 1:16
  int dv_list[3] = '{0, 3, 15};

  pmt_timer i_dut (
    .i_sys_clk(sys_clk),
    .i_rst_b(rst_b),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr),
    .o_irq(irq),
    .o_pwm_timebase(pwm),
    .o_spi_shift_clk(spi),
    .o_gate_pulse(gate)
  );

  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; pready and the answer are taken at the rising edge that completes it
  task automatic apb(input logic w, input logic [11:0] ix, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin chk("timeout", 0, 1); wrap_up(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] ix, input logic [31:0] e, input string nm,
                     input logic ee = 1'b0);
    apb(1'b0, ix, 32'h0);
    chk(nm, e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask : rdc

  // clocks from here to the next match pulse, bounded
  task automatic wait_pwm();
    t = 0;
    do begin @(negedge sys_clk); t++; end while (pwm !== 1'b1 && t < 5000);
    if (t >= 5000) begin chk("timeout", 0, 1); wrap_up(); end
  endtask : wait_pwm

  // main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdc(PMT_IDX_CONTROL, 32'(PMT_CONTROL_RST), "control");
    rdc(PMT_IDX_COUNT, 32'h00, "count");
    rdc(PMT_IDX_PERIOD, 32'hFF, "period");
    rdc(PMT_IDX_FLAG, 32'h00, "flag");
    rdc(12'h100, 32'h0, "unmapped", 1'b1);
    // stopped timer holds its count; control writes leave it alone
    apb(1'b1, PMT_IDX_COUNT, 32'h05);
    repeat (100) @(posedge sys_clk);
    rdc(PMT_IDX_COUNT, 32'h05, "held count");
    apb(1'b1, PMT_IDX_CONTROL, 32'hFF);
    apb(1'b1, PMT_IDX_CONTROL, 32'h78);
    rdc(PMT_IDX_CONTROL, 32'h78, "control rw");
    rdc(PMT_IDX_COUNT, 32'h05, "count kept");
    // match spacing for every prescale code, period 3
    apb(1'b1, PMT_IDX_PERIOD, 32'h03);
    rdc(PMT_IDX_PERIOD, 32'h03, "period rw");
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? 1 : (c == 1) ? 4 : 16;
      apb(1'b1, PMT_IDX_CONTROL, 32'h04 | 32'(c));
      wait_pwm();
      wait_pwm();
      chk("match spacing", 32'(16 * dv), 32'(t));
      chk("shift clock", 32'h1, {31'h0, spi});
      // gate pulse must last one instruction cycle, four system clocks
      @(negedge sys_clk);
      n = 0;
      while (gate === 1'b1 && n < 20) begin
        n++;
        @(negedge sys_clk);
      end
      chk("gate width", 32'(PMT_INSTR_DIV), 32'(n));
    end
    // postscaler ratios with the interrupt enabled
    apb(1'b1, PMT_IDX_CONTROL, 32'h00);
    apb(1'b1, PMT_IDX_PERIOD, 32'h01);
    apb(1'b1, PMT_IDX_ENABLE, 32'h02);
    foreach (dv_list[i]) begin
      apb(1'b1, PMT_IDX_COUNT, 32'h00);
      apb(1'b0, PMT_IDX_FLAG, 32'h0);
      apb(1'b1, PMT_IDX_CONTROL, 32'h04 | (32'(dv_list[i]) << 3));
      n = 0;
      t = 0;
      do begin
        @(negedge sys_clk);
        t++;
        if (pwm === 1'b1) n++;
      end while (irq !== 1'b1 && t < 5000);
      if (irq !== 1'b1) begin chk("timeout", 0, 1); wrap_up(); end
      chk("matches per irq", 32'(dv_list[i] + 1), 32'(n));
      apb(1'b1, PMT_IDX_CONTROL, 32'h00);
      rdc(PMT_IDX_FLAG, 32'h02, "flag set");
      rdc(PMT_IDX_FLAG, 32'h00, "flag cleared");
      chk("irq low", 32'h0, {31'h0, irq});
    end
    // masked: flag latches but the request stays low
    apb(1'b1, PMT_IDX_ENABLE, 32'h00);
    apb(1'b1, PMT_IDX_CONTROL, 32'h04);
    wait_pwm();
    wait_pwm();
    chk("masked irq", 32'h0, {31'h0, irq});
    apb(1'b1, PMT_IDX_CONTROL, 32'h00);
    rdc(PMT_IDX_FLAG, 32'h02, "masked flag");
    wrap_up();
  end

endmodule : tb_top
